// *** hw/comparator_pair_consts.vh ***
// Purpose: shared offsets, fields, reset values and counts for the comparator pair control
// Assumes: 32-bit APB, register index times four is the byte address
// Notes: definitions only
`ifndef COMPARATOR_PAIR_CONSTS_VH
`define COMPARATOR_PAIR_CONSTS_VH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_WINDOW_STATE 6'h08
`define IDX_SYNC_STATE 6'h09
`define IDX_WINDOW_STATE_MIRROR 6'h0a
`define IDX_WINDOW_CONFIG 6'h0c
`define IDX_COMP_CONFIG0 6'h10
`define IDX_COMP_CONFIG1 6'h14
`define IDX_IRQ_STATUS 6'h18
`define IDX_IRQ_CLEAR 6'h19
`define IDX_IRQ_ENABLE 6'h1a
`define IDX_SHOT_START 6'h1b

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_BUSY 7
`define POS_LO 4
`define POS_HI 5
`define BIT_WIN_ON 0
`define WIRQ_LO 1
`define WIRQ_HI 2
`define BIT_ENABLE 0
`define BIT_SINGLE 1
`define SPEED_LO 2
`define SPEED_HI 3
`define CIRQ_LO 5
`define CIRQ_HI 6
`define PSEL_LO 12
`define PSEL_HI 13
`define BIT_SWAP 15
`define ROUTE_LO 16
`define ROUTE_HI 17
`define BIT_HYSTERESIS_ON 19
`define FILTER_LENGTH_LO 24
`define FILTER_LENGTH_HI 26
`define IRQ_WIN_BIT 4

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define RST_WINDOW_CONFIG 8'h00
`define RST_COMP_CONFIG 32'h0000_0000
`define MASK_WINDOW_CONFIG 8'h07
`define MASK_COMP_FIELDS 32'h070b_b06e

// ----------------------------------------
// codes
// ----------------------------------------
`define POS_ABOVE 2'h0
`define POS_INSIDE 2'h1
`define POS_BELOW 2'h2
`define WIRQ_OUTSIDE 2'h3
`define CIRQ_TOGGLE 2'h0
`define CIRQ_RISING 2'h1
`define CIRQ_FALLING 2'h2
`define CIRQ_EOC 2'h3
`define FILTER_LENGTH_OFF 3'h0
`define FILTER_LENGTH_VOTE3 3'h1
`define FILTER_LENGTH_VOTE5 3'h2
`define ROUTE_OFF 2'h0
`define ROUTE_RAW 2'h1
`define ROUTE_FILTERED 2'h2

// ----------------------------------------
// timing counts
// ----------------------------------------
`define CMP_CLK_DIV 8'd4
`define SYNC_TICKS 3'd3

`endif

// *** hw/comparator_sample_filter.v ***
// Purpose: synchronise one comparator result and apply the majority vote filter
// Assumes: tick is a one-cycle enable at the comparator clock rate
// Notes: raw result is asynchronous to core_clk
`timescale 1ns/1ps
`include "comparator_pair_consts.vh"

module comparator_sample_filter (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // sampling
  input wire tick,
  input wire raw_result,
  input wire [2:0] filter_length,
  // result
  output reg filtered
);

  // ----------------------------------------
  // synchroniser and sample history
  // ----------------------------------------
  reg meta; // first stage, read only by sync_q
  reg sync_q; // safe sampled level
  reg [4:0] samples; // newest sample in bit 0

  // count of ones among all five bits
  function [2:0] ones;
    input [4:0] v;
    begin
      ones = {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]} + {2'b00, v[3]} + {2'b00, v[4]};
    end
  endfunction

  // two-flop synchroniser
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta <= raw_result;
      sync_q <= meta;
    end
  end

  // one sample per comparator clock
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      samples <= 5'h00;
    else if (tick)
      samples <= {samples[3:0], sync_q};
  end

  // vote over the most recent samples
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      filtered <= 1'b0;
    else
    begin
      case (filter_length)
        `FILTER_LENGTH_VOTE3: filtered <= (ones({2'b00, samples[2:0]}) >= 3'd2);
        `FILTER_LENGTH_VOTE5: filtered <= (ones(samples) >= 3'd3);
        default: filtered <= samples[0]; // off, reserved codes act as off
      endcase
    end
  end

endmodule // comparator_sample_filter

// *** hw/comparator_pair_window_control.v ***
// Purpose: control and status logic for a pair of comparators with window mode
// Assumes: APB slave, core_clk 250 MHz, comparator clock is a divided enable
// Notes: analog core lives outside; this block drives its selects and reads its results
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`include "comparator_pair_consts.vh"
module comparator_pair_window_control (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // analog comparator core
  input wire [1:0] raw_result,
  output wire [1:0] comparator_on,
  output wire [3:0] positive_input_select,
  output wire [1:0] swap_inputs,
  output wire [1:0] hysteresis_on,
  output wire [3:0] speed_select,
  // comparator pins
  output wire [1:0] comp_pin_out,
  output wire [1:0] comp_pin_oe,
  // interrupt
  output wire irq
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg [7:0] div_cnt; // comparator clock divider
  reg cmp_tick; // one-cycle comparator clock enable
  reg [7:0] window_config; // software view
  reg [31:0] comp_cfg0; // software view, comparator 0
  reg [31:0] comp_cfg1; // software view, comparator 1
  reg window_active; // window enable as seen by comparator domain
  reg [1:0] enable_active; // enables as seen by comparator domain
  reg busy; // domain transfer in progress
  reg [2:0] sync_cnt; // ticks into the transfer
  reg [1:0] window_position; // current window code
  reg [1:0] cmp_prev; // last result, for edge events
  reg [1:0] shot_pending; // single-shot requested, waiting for a tick
  reg [1:0] shot_val; // held single-shot result
  reg [1:0] eoc; // end of comparison, one cycle
  reg [4:0] irq_status; // sticky event bits
  reg [4:0] irq_enable; // event mask
  wire [1:0] filtered; // filter outputs, before swap
  wire [1:0] cmp_val; // resolved comparator results
  wire [1:0] cmp_evt; // comparator events this cycle
  wire win_evt; // window event this cycle
  wire setup; // apb setup cycle
  wire wr_access; // apb write taking effect
  wire [5:0] idx; // register index
  wire mapped; // index decodes
  wire [1:0] lock; // fields protected
  wire [1:0] pos_next; // next window code
  reg [31:0] rd_mux; // read data for current index
  // merge a control write, keeping locked fields
  function [31:0] merge_cfg;
    input [31:0] old;
    input [31:0] wdata;
    input locked;
    begin
      if (locked)
        merge_cfg = {old[31:1], wdata[`BIT_ENABLE]};
      else
        merge_cfg = (wdata & `MASK_COMP_FIELDS) | {31'h0, wdata[`BIT_ENABLE]};
    end
  endfunction

  // event selection per comparator condition
  function cmp_event;
    input [1:0] sel;
    input prev;
    input now;
    input single;
    input done;
    begin
      case (sel)
        `CIRQ_TOGGLE: cmp_event = prev ^ now;
        `CIRQ_RISING: cmp_event = ~prev & now;
        `CIRQ_FALLING: cmp_event = prev & ~now;
        `CIRQ_EOC: cmp_event = single & done; // only meaningful in single-shot
        default: cmp_event = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // comparator clock divider
  // ----------------------------------------
  // single clock design: the comparator domain is a tick enable
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_cnt <= 8'h00;
      cmp_tick <= 1'b0;
    end
    else if (div_cnt == `CMP_CLK_DIV - 8'd1)
    begin
      div_cnt <= 8'h00;
      cmp_tick <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 8'd1;
      cmp_tick <= 1'b0;
    end
  end
  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  assign setup = psel & ~penable;
  assign wr_access = psel & penable & pwrite;
  assign idx = paddr[7:2];
  assign pready = 1'b1; // zero wait states
  assign mapped = (idx == `IDX_WINDOW_STATE) | (idx == `IDX_SYNC_STATE) | (idx == `IDX_WINDOW_STATE_MIRROR) |
                  (idx == `IDX_WINDOW_CONFIG) | (idx == `IDX_COMP_CONFIG0) | (idx == `IDX_COMP_CONFIG1) |
                  (idx == `IDX_IRQ_STATUS) | (idx == `IDX_IRQ_CLEAR) | (idx == `IDX_IRQ_ENABLE) |
                  (idx == `IDX_SHOT_START);
  assign pslverr = psel & penable & ~mapped; // unmapped index
  // locked from enable write until the disable has crossed over
  assign lock = {comp_cfg1[`BIT_ENABLE] | enable_active[1], comp_cfg0[`BIT_ENABLE] | enable_active[0]};
  // read mux
  always @*
  begin
    case (idx)
      `IDX_WINDOW_STATE: rd_mux = {26'h0, window_position, 4'h0};
      `IDX_WINDOW_STATE_MIRROR: rd_mux = {26'h0, window_position, 4'h0};
      `IDX_SYNC_STATE: rd_mux = {24'h0, busy, 7'h00};
      `IDX_WINDOW_CONFIG: rd_mux = {24'h0, window_config};
      `IDX_COMP_CONFIG0: rd_mux = comp_cfg0;
      `IDX_COMP_CONFIG1: rd_mux = comp_cfg1;
      `IDX_IRQ_STATUS: rd_mux = {27'h0, irq_status};
      `IDX_IRQ_ENABLE: rd_mux = {27'h0, irq_enable};
      default: rd_mux = 32'h0000_0000; // write-only and unmapped read zero
    endcase
  end
  // read data captured in setup, stable through access
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      prdata <= 32'h0000_0000;
    else if (setup & ~pwrite)
      prdata <= rd_mux;
  end
  // ----------------------------------------
  // control registers
  // ----------------------------------------
  // software-visible control, written at the access edge
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      window_config <= `RST_WINDOW_CONFIG;
      comp_cfg0 <= `RST_COMP_CONFIG;
      comp_cfg1 <= `RST_COMP_CONFIG;
      irq_enable <= 5'h00;
    end
    else if (wr_access)
    begin
      if (idx == `IDX_WINDOW_CONFIG)
        window_config <= pwdata[7:0] & `MASK_WINDOW_CONFIG;
      if (idx == `IDX_COMP_CONFIG0)
        comp_cfg0 <= merge_cfg(comp_cfg0, pwdata, lock[0]);
      if (idx == `IDX_COMP_CONFIG1)
        comp_cfg1 <= merge_cfg(comp_cfg1, pwdata, lock[1]);
      if (idx == `IDX_IRQ_ENABLE)
        irq_enable <= pwdata[4:0];
    end
  end
  // ----------------------------------------
  // domain transfer of window and enable bits
  // ----------------------------------------
  // a new write restarts the transfer; the latest value wins
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busy <= 1'b0;
      sync_cnt <= 3'd0;
      window_active <= 1'b0;
      enable_active <= 2'b00;
    end
    else if (wr_access & ((idx == `IDX_WINDOW_CONFIG) | (idx == `IDX_COMP_CONFIG0) | (idx == `IDX_COMP_CONFIG1)))
    begin
      busy <= 1'b1;
      sync_cnt <= 3'd0;
    end
    else if (busy & cmp_tick)
    begin
      if (sync_cnt == `SYNC_TICKS - 3'd1)
      begin
        busy <= 1'b0;
        window_active <= window_config[`BIT_WIN_ON];
        enable_active <= {comp_cfg1[`BIT_ENABLE], comp_cfg0[`BIT_ENABLE]};
      end
      else
        sync_cnt <= sync_cnt + 3'd1;
    end
  end
  // ----------------------------------------
  // analog core steering (fields act at once, enable after the transfer)
  // ----------------------------------------
  assign comparator_on = enable_active;
  assign positive_input_select = {comp_cfg1[`PSEL_HI:`PSEL_LO], comp_cfg0[`PSEL_HI:`PSEL_LO]};
  assign swap_inputs = {comp_cfg1[`BIT_SWAP], comp_cfg0[`BIT_SWAP]};
  assign speed_select = {comp_cfg1[`SPEED_HI:`SPEED_LO], comp_cfg0[`SPEED_HI:`SPEED_LO]};
  // hysteresis is meaningless for a single comparison
  assign hysteresis_on = {comp_cfg1[`BIT_HYSTERESIS_ON] & ~comp_cfg1[`BIT_SINGLE],
                          comp_cfg0[`BIT_HYSTERESIS_ON] & ~comp_cfg0[`BIT_SINGLE]};
  // ----------------------------------------
  // sampling and filtering
  // ----------------------------------------
  comparator_sample_filter u_filter0 (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tick(cmp_tick),
    .raw_result(raw_result[0]),
    .filter_length(comp_cfg0[`FILTER_LENGTH_HI:`FILTER_LENGTH_LO]),
    .filtered(filtered[0])
  );
  comparator_sample_filter u_filter1 (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tick(cmp_tick),
    .raw_result(raw_result[1]),
    .filter_length(comp_cfg1[`FILTER_LENGTH_HI:`FILTER_LENGTH_LO]),
    .filtered(filtered[1])
  );
  // swapped inputs flip the sense of the result
  assign cmp_val[0] = comp_cfg0[`BIT_SINGLE] ? shot_val[0] : (filtered[0] ^ comp_cfg0[`BIT_SWAP]);
  assign cmp_val[1] = comp_cfg1[`BIT_SINGLE] ? shot_val[1] : (filtered[1] ^ comp_cfg1[`BIT_SWAP]);
  // ----------------------------------------
  // single-shot and edge history
  // ----------------------------------------
  // a shot request waits for the next comparator tick, then holds
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shot_pending <= 2'b00;
      shot_val <= 2'b00;
      eoc <= 2'b00;
      cmp_prev <= 2'b00;
    end
    else
    begin
      eoc <= 2'b00;
      if (wr_access & (idx == `IDX_SHOT_START))
        shot_pending <= shot_pending | (pwdata[1:0] & enable_active &
                        {comp_cfg1[`BIT_SINGLE], comp_cfg0[`BIT_SINGLE]});
      else if (cmp_tick)
      begin
        shot_pending <= 2'b00;
        shot_val[0] <= shot_pending[0] ? (filtered[0] ^ comp_cfg0[`BIT_SWAP]) : shot_val[0];
        shot_val[1] <= shot_pending[1] ? (filtered[1] ^ comp_cfg1[`BIT_SWAP]) : shot_val[1];
        eoc <= shot_pending;
      end
      if (cmp_tick)
        cmp_prev <= cmp_val & enable_active;
    end
  end
  assign cmp_evt[0] = enable_active[0] & (cmp_tick | eoc[0]) &
                      cmp_event(comp_cfg0[`CIRQ_HI:`CIRQ_LO], cmp_prev[0], cmp_val[0], comp_cfg0[`BIT_SINGLE], eoc[0]);
  assign cmp_evt[1] = enable_active[1] & (cmp_tick | eoc[1]) &
                      cmp_event(comp_cfg1[`CIRQ_HI:`CIRQ_LO], cmp_prev[1], cmp_val[1], comp_cfg1[`BIT_SINGLE], eoc[1]);
  // ----------------------------------------
  // window mode
  // ----------------------------------------
  // comparator 0 watches the upper limit, comparator 1 the lower
  assign pos_next = cmp_val[0] ? `POS_ABOVE : (cmp_val[1] ? `POS_INSIDE : `POS_BELOW);
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      window_position <= `POS_ABOVE;
    else if (cmp_tick & window_active & (&enable_active))
      window_position <= pos_next;
  end
  // event when the position newly meets the chosen condition
  assign win_evt = cmp_tick & window_active & (&enable_active) & (pos_next != window_position) &
                   ((window_config[`WIRQ_HI:`WIRQ_LO] == `WIRQ_OUTSIDE) ? (pos_next != `POS_INSIDE) :
                    (pos_next == window_config[`WIRQ_HI:`WIRQ_LO]));
  // ----------------------------------------
  // interrupt status
  // ----------------------------------------
  // set wins over a clear in the same cycle
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      irq_status <= 5'h00;
    else
      irq_status <= (irq_status & ~((wr_access & (idx == `IDX_IRQ_CLEAR)) ? pwdata[4:0] : 5'h00)) |
                    {win_evt, 2'b00, cmp_evt & ~{2{window_active}}};
  end
  assign irq = |(irq_status & irq_enable);
  // ----------------------------------------
  // output pins
  // ----------------------------------------
  // raw path bypasses the synchroniser, so it may glitch
  assign comp_pin_oe[0] = enable_active[0] & ((comp_cfg0[`ROUTE_HI:`ROUTE_LO] == `ROUTE_RAW) |
                          (comp_cfg0[`ROUTE_HI:`ROUTE_LO] == `ROUTE_FILTERED));
  assign comp_pin_oe[1] = enable_active[1] & ((comp_cfg1[`ROUTE_HI:`ROUTE_LO] == `ROUTE_RAW) |
                          (comp_cfg1[`ROUTE_HI:`ROUTE_LO] == `ROUTE_FILTERED));
  assign comp_pin_out[0] = comp_pin_oe[0] & ((comp_cfg0[`ROUTE_HI:`ROUTE_LO] == `ROUTE_RAW) ?
                           (raw_result[0] ^ comp_cfg0[`BIT_SWAP]) : cmp_val[0]);
  assign comp_pin_out[1] = comp_pin_oe[1] & ((comp_cfg1[`ROUTE_HI:`ROUTE_LO] == `ROUTE_RAW) ?
                           (raw_result[1] ^ comp_cfg1[`BIT_SWAP]) : cmp_val[1]);
endmodule // comparator_pair_window_control

// *** sim/comparator_pair_checker.sv ***
// Purpose: port-level checker for the comparator pair control block
// Assumes: zero wait apb slave, one clock domain
// Notes: bound to the top module at the foot of this file
`timescale 1ns/1ps
`include "comparator_pair_consts.vh"
module comparator_pair_checker (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // analog core
  input wire [1:0] raw_result,
  input wire [1:0] comparator_on,
  input wire [3:0] positive_input_select,
  input wire [1:0] swap_inputs,
  input wire [1:0] hysteresis_on,
  input wire [3:0] speed_select,
  // pins and interrupt
  input wire [1:0] comp_pin_out,
  input wire [1:0] comp_pin_oe,
  input wire irq
);
  // ----------------------------------------
  // helper decode
  // ----------------------------------------
  wire acc = psel && penable; // access phase
  wire rdacc = acc && !pwrite; // read access
  wire [5:0] idx = paddr[7:2]; // word index
  wire mapped = idx == `IDX_WINDOW_STATE || idx == `IDX_SYNC_STATE || idx == `IDX_WINDOW_STATE_MIRROR
    || idx == `IDX_WINDOW_CONFIG || idx == `IDX_COMP_CONFIG0 || idx == `IDX_COMP_CONFIG1
    || idx == `IDX_IRQ_STATUS || idx == `IDX_IRQ_CLEAR || idx == `IDX_IRQ_ENABLE || idx == `IDX_SHOT_START;
  wire sync_wr = acc && pwrite && (idx == `IDX_WINDOW_CONFIG || idx == `IDX_COMP_CONFIG0
    || idx == `IDX_COMP_CONFIG1); // writes that start a transfer
  reg [4:0] since_wr; // cycles since last synchronised write, saturates
  // age counter; saturating keeps old writes from wrapping into range
  always @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      since_wr <= 5'h1f;
    else if (sync_wr)
      since_wr <= 5'h00;
    else if (since_wr != 5'h1f)
      since_wr <= since_wr + 5'h01;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_err_unmapped: assert property (pslverr == (acc && !mapped))
    else $error("slave error does not match decode");
  a_ready_zero_wait: assert property (acc |-> pready)
    else $error("ready low in access phase");
  a_unmapped_zero: assert property (rdacc && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_busy_layout: assert property (rdacc && idx == `IDX_SYNC_STATE |-> (prdata & 32'hffff_ff7f) == 32'h0)
    else $error("sync state has bits beside busy");
  a_position_code: assert property (rdacc && (idx == `IDX_WINDOW_STATE || idx == `IDX_WINDOW_STATE_MIRROR)
    |-> (prdata & 32'hffff_ffcf) == 32'h0 && prdata[5:4] != 2'h3)
    else $error("window position code illegal");
  a_pin_quiet: assert property ((comp_pin_out & ~comp_pin_oe) == 2'h0)
    else $error("pin value without enable");
  a_pin_needs_on: assert property ((comp_pin_oe & ~comparator_on) == 2'h0)
    else $error("pin driven by disabled comparator");
  a_on_after_sync: assert property ($changed(comparator_on) |-> since_wr >= 5'd8 && since_wr <= 5'd13)
    else $error("enable changed outside sync window");
  a_fields_by_write: assert property (
    $changed({positive_input_select, swap_inputs, hysteresis_on, speed_select}) |-> $past(sync_wr))
    else $error("config outputs changed without write");
  a_irq_masked: assert property (acc && pwrite && idx == `IDX_IRQ_ENABLE && pwdata == 32'h0 |=> !irq)
    else $error("irq high with all enables off");
  c_sync: cover property (sync_wr);
  c_pin: cover property (comp_pin_oe != 2'h0);
  c_irq: cover property (irq);
endmodule // comparator_pair_checker

bind comparator_pair_window_control comparator_pair_checker chk (.core_clk, .arst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .raw_result, .comparator_on, .positive_input_select,
  .swap_inputs, .hysteresis_on, .speed_select, .comp_pin_out, .comp_pin_oe, .irq);

// *** sim/comparator_pair_window_control_test.sv ***
// Purpose: self-checking bench for the comparator pair control block
// Assumes: zero wait apb, comparator tick every 4 core cycles
// Notes: 16-cycle settles cover the 12-cycle worst case sync
`timescale 1ns/1ps
`include "comparator_pair_consts.vh"
module comparator_pair_window_control_test;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  reg core_clk = 1'b0;
  reg arst_n = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [31:0] paddr = 32'h0;
  reg [31:0] pwdata = 32'h0;
  reg [1:0] raw_result = 2'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [1:0] comparator_on;
  wire [3:0] positive_input_select;
  wire [1:0] swap_inputs;
  wire [1:0] hysteresis_on;
  wire [3:0] speed_select;
  wire [1:0] comp_pin_out;
  wire [1:0] comp_pin_oe;
  wire irq;
  integer n_mismatch = 0;
  integer num_checks = 0;
  integer i;
  integer k;
  reg [31:0] rd; // last read data
  reg err; // last slave error
  reg [31:0] v; // config word
  reg seen; // pin went high
  localparam [63:0] RST_ADDRS = 64'h2024_2830_4050_6068;
  always #2 core_clk = ~core_clk; // 250 MHz
  comparator_pair_window_control uut (.core_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .raw_result, .comparator_on, .positive_input_select, .swap_inputs,
    .hysteresis_on, .speed_select, .comp_pin_out, .comp_pin_oe, .irq);
  // ----------------------------------------
  // tasks and expectations
  // ----------------------------------------
  task check(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // one apb transfer; idles a cycle after so strobes never re-assert in one step
  task apb(input w, input [31:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1)
        @(posedge core_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task settle(input integer n);
    repeat (n) @(posedge core_clk);
  endtask
  task cfg(input integer c, input [31:0] d);
    begin
      apb(1'b1, c ? 32'h50 : 32'h40, d);
      settle(16);
    end
  endtask
  function [1:0] pos_code(input [1:0] r); // window position from both results
    pos_code = r[0] ? 2'h0 : (r[1] ? 2'h1 : 2'h2);
  endfunction
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // watchdog cuts a hang short
  initial
  begin
    settle(20000);
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    v = $urandom(32'head48972);
    settle(10);
    arst_n <= 1'b1;
    settle(1);
    for (i = 0; i < 8; i = i + 1)
    begin
      apb(1'b0, {24'h0, RST_ADDRS[63-8*i -: 8]}, 32'h0);
      check(rd, 32'h0);
    end
    apb(1'b0, 32'h0, 32'h0);
    check({rd[30:0], err}, 32'h1);
    $display("reset values done");
    apb(1'b1, 32'h30, 32'h0);
    apb(1'b0, 32'h24, 32'h0);
    check(rd, 32'h80);
    settle(16);
    apb(1'b0, 32'h24, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 32'h68, 32'h0);
    apb(1'b0, 32'h24, 32'h0);
    check(rd, 32'h0);
    $display("busy flag done");
    for (i = 0; i < 8; i = i + 1)
    begin
      k = i % 2;
      v = (i == 0) ? `MASK_COMP_FIELDS : (i == 1) ? 32'h0008_0000 : $urandom & `MASK_COMP_FIELDS;
      apb(1'b1, k ? 32'h50 : 32'h40, v);
      apb(1'b0, k ? 32'h50 : 32'h40, 32'h0);
      check(rd, v);
      check(positive_input_select[2*k +: 2], v[13:12]);
      check(swap_inputs[k], v[15]);
      check(hysteresis_on[k], v[19] & ~v[1]);
      check(speed_select[2*k +: 2], v[3:2]);
    end
    $display("field writes done");
    cfg(0, 32'h1001);
    check(comparator_on, 2'h1);
    apb(1'b1, 32'h40, 32'h2001);
    apb(1'b0, 32'h40, 32'h0);
    check(rd, 32'h1001);
    cfg(0, 32'h0);
    check(comparator_on, 2'h0);
    apb(1'b1, 32'h40, 32'h2000);
    apb(1'b0, 32'h40, 32'h0);
    check(rd, 32'h2000);
    $display("lock done");
    for (i = 0; i < 4; i = i + 1)
    begin
      cfg(1, (i << 16) | 1);
      raw_result <= 2'h2;
      settle(24);
      check(comp_pin_oe[1], i == 1 || i == 2);
      check(comp_pin_out[1], i == 1 || i == 2);
      raw_result <= 2'h0;
      cfg(1, 32'h0);
    end
    // a pulse one tick long: kept with no filter, voted away by both majorities
    for (i = 0; i < 4; i = i + 1)
    begin
      cfg(1, (i << 24) | 32'h2_0001);
      seen = 1'b0;
      raw_result <= 2'h2;
      settle(4);
      raw_result <= 2'h0;
      repeat (30)
      begin
        @(posedge core_clk);
        seen = seen | comp_pin_out[1];
      end
      check(seen, i != 1 && i != 2);
      cfg(1, 32'h0);
    end
    $display("routing and filter done");
    cfg(0, 32'h1);
    cfg(1, 32'h1);
    apb(1'b1, 32'h68, 32'h10);
    for (i = 0; i < 4; i = i + 1)
    begin
      apb(1'b1, 32'h30, (i << 1) | 1);
      raw_result <= (i == 1) ? 2'h0 : 2'h2;
      settle(30);
      apb(1'b1, 32'h64, 32'h1f);
      v = (i == 0) ? 32'h1 : (i == 1) ? 32'h2 : 32'h0;
      raw_result <= v[1:0];
      settle(30);
      apb(1'b0, 32'h20, 32'h0);
      check(rd[5:4], pos_code(v[1:0]));
      apb(1'b0, 32'h28, 32'h0);
      check(rd[5:4], pos_code(v[1:0]));
      apb(1'b0, 32'h60, 32'h0);
      check(rd, 32'h10);
      check(irq, 1'b1);
    end
    apb(1'b1, 32'h68, 32'h0);
    check(irq, 1'b0);
    apb(1'b1, 32'h68, 32'h10);
    check(irq, 1'b1);
    apb(1'b1, 32'h64, 32'h10);
    check(irq, 1'b0);
    apb(1'b1, 32'h30, 32'h0);
    settle(16);
    $display("window done");
    apb(1'b1, 32'h68, 32'h1);
    for (i = 0; i < 4; i = i + 1)
    begin
      cfg(0, 32'h0);
      cfg(0, (i << 5) | ((i == 3) << 1) | 32'h8_0001);
      check(hysteresis_on[0], i != 3);
      raw_result <= 2'h0;
      settle(30);
      apb(1'b1, 32'h64, 32'h1f);
      if (i == 3)
        apb(1'b1, 32'h6c, 32'h1);
      else
        raw_result <= 2'h1;
      settle(30);
      apb(1'b0, 32'h60, 32'h0);
      check(rd[0], i != 2);
    end
    $display("comparator events done");
    complete_run;
  end
endmodule // comparator_pair_window_control_test
